// file: include/hmc_pkg.sv
package hmc_pkg;

  // clock rate and derived cycle counts
  localparam int CLK_MHZ          = 40;
  localparam int EOC_PULSE_MIN_NS = 1800;
  localparam int EOC_PULSE_TYP_NS = 2500;
  localparam int EOC_PULSE_MAX_NS = 3200;
  localparam int EOC_PULSE_CYC    = (EOC_PULSE_TYP_NS * CLK_MHZ) / 1000;
  // per-channel conversion slot equals the typical next-read spacing
  localparam int CONV_FR_NS       = 43000;
  localparam int CONV_SR_NS       = 59000;
  localparam int CONV_FR_CYC      = (CONV_FR_NS * CLK_MHZ) / 1000;
  localparam int CONV_SR_CYC      = (CONV_SR_NS * CLK_MHZ) / 1000;
  localparam int TMR_W            = 12;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W  = 12;

  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_TRIG     = 8'h10;
  localparam logic [7:0] REG_PERIOD   = 8'h14;
  localparam logic [7:0] REG_RES_X    = 8'h18;
  localparam logic [7:0] REG_RES_Y    = 8'h1C;
  localparam logic [7:0] REG_RES_Z    = 8'h20;
  localparam logic [7:0] REG_RES_T    = 8'h24;

  // control fields
  localparam int CTRL_FAST_BIT  = 0;
  localparam int CTRL_CFG_LSB   = 1;
  localparam int CTRL_EOC_BIT   = 3;
  localparam int CTRL_SR_BIT    = 4;
  localparam int CTRL_ITRIG_BIT = 5;
  localparam int CTRL_W         = 6;
  localparam logic [5:0] CTRL_RST = 6'h08;
  localparam logic [15:0] PERIOD_RST = 16'h1000;

  // interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_DROP_BIT = 1;
  localparam int IRQ_W        = 2;

  // channel numbers and measurement configurations
  localparam logic [1:0] CH_X = 2'h0;
  localparam logic [1:0] CH_Y = 2'h1;
  localparam logic [1:0] CH_Z = 2'h2;
  localparam logic [1:0] CH_T = 2'h3;

  typedef enum logic [1:0] {
    HMC_CFG_XYZT = 2'h0,
    HMC_CFG_XYZ  = 2'h1,
    HMC_CFG_XY   = 2'h2
  } hmc_cfg_type;

  typedef enum logic [1:0] {
    HMC_IDLE = 2'b01,
    HMC_CONV = 2'b10
  } hmc_state_type;

endpackage

// file: logic/hmc_cycle_timer.sv
`timescale 1ns/1ps
module hmc_cycle_timer
  import hmc_pkg::*;
#(
  parameter int W = 12
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] len,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_r;

  // busy stays high for exactly len cycles; a start wins over the end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (start) begin
      cnt_r <= len - W'(1);
      busy  <= 1'b1;
      done  <= 1'b0;
    end else if (busy && cnt_r == '0) begin
      busy  <= 1'b0;
      done  <= 1'b1;
    end else begin
      cnt_r <= busy ? cnt_r - W'(1) : cnt_r;
      done  <= 1'b0;
    end
  end

endmodule // hmc_cycle_timer

// file: logic/hmc_rate_div.sv
`timescale 1ns/1ps
module hmc_rate_div
  import hmc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         en,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] cnt_r;

  // one-cycle tick every period cycles; a zero period never ticks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (!en || period == '0) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r >= period - W'(1)) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + W'(1);
      tick  <= 1'b0;
    end
  end

endmodule // hmc_rate_div

// file: logic/hmc_top.sv
`timescale 1ns/1ps
module hmc_top
  import hmc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              ext_trig,
  input  wire logic [RES_W-1:0]  adc_data,
  output logic      [1:0]        adc_ch,
  output logic                   adc_conv,
  output logic                   eoc_n,
  output logic                   irq
);

  localparam logic [TMR_W-1:0] EOC_LEN = TMR_W'(EOC_PULSE_CYC);
  localparam logic [TMR_W-1:0] FR_LEN  = TMR_W'(CONV_FR_CYC);
  localparam logic [TMR_W-1:0] SR_LEN  = TMR_W'(CONV_SR_CYC);

  // software-visible state
  logic [CTRL_W-1:0] ctrl_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [15:0]       period_r;
  logic              sw_trig_r;
  logic [7:0]        cycle_cnt_r;

  // sequencer state
  hmc_state_type     state_r;
  hmc_state_type     state_nxt;
  logic [1:0]        ch_r;
  logic [1:0]        ch_nxt;
  logic              trig_pend_r;
  logic [RES_W-1:0]  work_r   [4];
  logic [RES_W-1:0]  result_r [4];
  logic [DATA_W-1:0] rdata_r;
  logic              eoc_n_r;
  logic              irq_r;

  // decoded control fields
  logic              fast_mode;
  hmc_cfg_type       cfg;
  logic              eoc_en;
  logic              short_rng;
  logic              itrig_en;
  logic [1:0]        last_ch;

  // timer hookups
  logic              conv_start;
  logic              conv_busy;
  logic              conv_done;
  logic              eoc_start;
  logic              eoc_busy;
  logic              itick;
  logic              cycle_end;
  logic              trig_any;
  logic              trig_drop;

  assign fast_mode = ctrl_r[CTRL_FAST_BIT];
  assign cfg       = hmc_cfg_type'(ctrl_r[CTRL_CFG_LSB +: 2]);
  assign eoc_en    = ctrl_r[CTRL_EOC_BIT];
  assign short_rng = ctrl_r[CTRL_SR_BIT];
  assign itrig_en  = ctrl_r[CTRL_ITRIG_BIT];

  // last channel of the active configuration
  always_comb begin
    case (cfg)
      HMC_CFG_XYZT: last_ch = CH_T;
      HMC_CFG_XYZ:  last_ch = CH_Z;
      HMC_CFG_XY:   last_ch = CH_Y;
      default:      last_ch = CH_T;
    endcase
  end

  // internal trigger source, a slow tick from the period register
  hmc_rate_div #(
    .W      (16)
  ) u_itrig (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .en      (itrig_en),
    .period  (period_r),
    .tick    (itick)
  );

  // per-channel conversion slot; its length sets the read spacing
  hmc_cycle_timer #(
    .W       (TMR_W)
  ) u_conv (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (conv_start),
    .len     (short_rng ? SR_LEN : FR_LEN),
    .busy    (conv_busy),
    .done    (conv_done)
  );

  // end-of-conversion pulse width
  hmc_cycle_timer #(
    .W       (TMR_W)
  ) u_eoc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (eoc_start),
    .len     (EOC_LEN),
    .busy    (eoc_busy),
    .done    ()
  );

  // any trigger source; in fast mode triggers are not needed
  assign trig_any  = ext_trig | itick | sw_trig_r;
  assign cycle_end = state_r == HMC_CONV && conv_done && ch_r == last_ch;
  // a trigger landing on a busy sequencer that already holds one is lost
  assign trig_drop = trig_any && !fast_mode && trig_pend_r &&
                     state_r == HMC_CONV;

  // sequencer next state
  always_comb begin
    state_nxt  = state_r;
    ch_nxt     = ch_r;
    conv_start = 1'b0;
    case (state_r)
      HMC_IDLE: begin
        if (fast_mode || trig_pend_r) begin
          state_nxt  = HMC_CONV;
          ch_nxt     = CH_X;
          conv_start = 1'b1;
        end
      end
      HMC_CONV: begin
        if (conv_done) begin
          if (ch_r != last_ch) begin
            ch_nxt     = ch_r + 2'h1;
            conv_start = 1'b1;
          end else if (fast_mode || trig_pend_r) begin
            // back-to-back cycle with no idle gap
            ch_nxt     = CH_X;
            conv_start = 1'b1;
          end else begin
            state_nxt  = HMC_IDLE;
          end
        end
      end
      default: begin
        state_nxt = HMC_IDLE;
        ch_nxt    = CH_X;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= HMC_IDLE;
      ch_r    <= CH_X;
    end else begin
      state_r <= state_nxt;
      ch_r    <= ch_nxt;
    end
  end

  // trigger memory: one request is held while a cycle runs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trig_pend_r <= 1'b0;
    end else if (fast_mode) begin
      trig_pend_r <= 1'b0;
    end else if (trig_any) begin
      trig_pend_r <= 1'b1;
    end else if (conv_start && ch_nxt == CH_X) begin
      trig_pend_r <= 1'b0;
    end
  end

  // working copy of each converted channel; skipped ones never change
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        work_r[i] <= '0;
      end
    end else if (state_r == HMC_CONV && conv_done) begin
      work_r[ch_r] <= adc_data;
    end
  end

  // results publish only at cycle end, so the host sees a whole set
  // that holds through every read window of the next cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        result_r[i] <= '0;
      end
    end else if (cycle_end) begin
      for (int i = 0; i < 4; i++) begin
        // the last channel arrives this cycle straight from the converter
        if (i[1:0] == ch_r) begin
          result_r[i] <= adc_data;
        end else if (i[1:0] < ch_r) begin
          result_r[i] <= work_r[i];
        end
      end
    end
  end

  // eoc starts two cycles after the results land, never before
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eoc_start <= 1'b0;
    end else begin
      eoc_start <= cycle_end && eoc_en;
    end
  end

  // low-active pulse straight from a flop, EOC_LEN cycles wide
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eoc_n_r <= 1'b1;
    end else begin
      eoc_n_r <= ~eoc_busy;
    end
  end

  // converter pins follow the sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      adc_ch   <= CH_X;
      adc_conv <= 1'b0;
    end else begin
      adc_ch   <= ch_nxt;
      adc_conv <= state_nxt == HMC_CONV;
    end
  end

  // completed-cycle counter, wraps freely
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cycle_cnt_r <= '0;
    end else if (cycle_end) begin
      cycle_cnt_r <= cycle_cnt_r + 8'h01;
    end
  end

  // control, mask and period writes; the trigger bit self-clears
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r     <= CTRL_RST;
      irq_mask_r <= '0;
      period_r   <= PERIOD_RST;
      sw_trig_r  <= 1'b0;
    end else begin
      sw_trig_r <= wr && addr == REG_TRIG && wdata[0];
      if (wr && addr == REG_CTRL) begin
        ctrl_r <= wdata[CTRL_W-1:0];
      end
      if (wr && addr == REG_IRQ_MASK) begin
        irq_mask_r <= wdata[IRQ_W-1:0];
      end
      if (wr && addr == REG_PERIOD) begin
        period_r <= wdata[15:0];
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE_BIT && cycle_end) ||
            (i == IRQ_DROP_BIT && trig_drop)) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr && addr == REG_IRQ_STAT && wdata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  // level interrupt while any unmasked event is pending
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read data valid the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (rd) begin
      case (addr)
        REG_CTRL:     rdata_r <= DATA_W'(ctrl_r);
        REG_STATUS:   rdata_r <= {16'h0000, cycle_cnt_r, 3'h0,
                                  conv_busy, ch_r, state_r};
        REG_IRQ_STAT: rdata_r <= DATA_W'(irq_stat_r);
        REG_IRQ_MASK: rdata_r <= DATA_W'(irq_mask_r);
        REG_PERIOD:   rdata_r <= DATA_W'(period_r);
        REG_RES_X:    rdata_r <= DATA_W'(result_r[CH_X]);
        REG_RES_Y:    rdata_r <= DATA_W'(result_r[CH_Y]);
        REG_RES_Z:    rdata_r <= DATA_W'(result_r[CH_Z]);
        REG_RES_T:    rdata_r <= DATA_W'(result_r[CH_T]);
        default:      rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata = rdata_r;
  assign eoc_n = eoc_n_r;
  assign irq   = irq_r;

endmodule // hmc_top

// file: test/hmc_adc_model.sv
`timescale 1ns/1ps
module hmc_adc_model
  import hmc_pkg::*;
(
  input  wire logic [1:0]       ch,
  input  wire logic [9:0]       offs,
  output logic      [RES_W-1:0] data
);
  // channel number in the low bits so a swapped slot shows at once
  assign data = {offs, ch};
endmodule // hmc_adc_model

// file: test/hmc_top_asserts.sv
`timescale 1ns/1ps
module hmc_top_asserts
  import hmc_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              ext_trig,
  input wire logic [RES_W-1:0]  adc_data,
  input wire logic [1:0]        adc_ch,
  input wire logic              adc_conv,
  input wire logic              eoc_n,
  input wire logic              irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [11:0] low_cnt_r;
  logic [11:0] slot_cnt_r;
  logic [1:0]  prev_ch_r;
  logic        prev_conv_r;
  // pulse too long to unroll, so count its low cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_r <= 12'h000;
    end else if (eoc_n) begin
      low_cnt_r <= 12'h000;
    end else begin
      low_cnt_r <= low_cnt_r + 12'h001;
    end
  end
  // slot length counter, restarts on every channel change and when a
  // cycle starts, so the first slot of a cycle is not counted one long
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slot_cnt_r  <= 12'h000;
      prev_ch_r   <= 2'h0;
      prev_conv_r <= 1'b0;
    end else begin
      prev_ch_r   <= adc_ch;
      prev_conv_r <= adc_conv;
      if (adc_conv && prev_conv_r && adc_ch == prev_ch_r) begin
        slot_cnt_r <= slot_cnt_r + 12'h001;
      end else begin
        slot_cnt_r <= 12'h000;
      end
    end
  end
  sequence eoc_start_s; $fell(eoc_n); endsequence
  sequence conv_end_s; $fell(adc_conv); endsequence
  sequence ch_step_s; adc_conv && $past(adc_conv) && adc_ch != prev_ch_r;
  endsequence
  AST_EOC_WIDTH: assert property ($rose(eoc_n) |->
    low_cnt_r == EOC_PULSE_CYC) else $error("eoc pulse width wrong");
  AST_EOC_GAP: assert property ($rose(eoc_n) |=> eoc_n [*8])
    else $error("eoc pulse retriggered");
  AST_EOC_AFTER_CONV: assert property (conv_end_s |-> ##[1:4] eoc_start_s)
    else $error("no eoc after cycle end");
  AST_START_X: assert property ($rose(adc_conv) |-> adc_ch == CH_X)
    else $error("cycle did not start on x");
  AST_CH_ORDER: assert property (ch_step_s |->
    adc_ch == prev_ch_r + 2'h1 || adc_ch == CH_X)
    else $error("channel order broken");
  AST_SLOT_LEN: assert property (ch_step_s |-> slot_cnt_r inside
    {[CONV_FR_CYC-2:CONV_FR_CYC], [CONV_SR_CYC-2:CONV_SR_CYC]})
    else $error("slot length wrong");
  AST_EXT_START: assert property (ext_trig && !adc_conv |->
    ##[1:3] adc_conv) else $error("trigger did not start a cycle");
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside read slot");
  AST_RD_UNMAPPED: assert property (rd && addr >= 8'h28 |=> rdata == '0)
    else $error("unmapped read not zero");
  AST_IRQ_STICKY: assert property (irq && !wr && !$past(wr) |=> irq)
    else $error("irq dropped without a write");
endmodule // hmc_top_asserts

// file: test/test_hmc_top.sv
`timescale 1ns/1ps
module test_hmc_top
  import hmc_pkg::*;
;
  typedef struct { logic [31:0] ctrl; int nch; int len; } hmc_row_type;
  logic              ref_clk, rstn, wr, rd, ext_trig, adc_conv, eoc_n, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rv;
  logic [RES_W-1:0]  adc_data;
  logic [RES_W-1:0]  exp_res [4];
  logic [1:0]        adc_ch;
  logic [9:0]        offs;
  logic [39:0]       rst_tab [6];
  hmc_row_type       rows [4];
  int                n_errors, checked, cnt, cyc, mx;
  hmc_top dut_u (.ref_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .ext_trig,
    .adc_data, .adc_ch, .adc_conv, .eoc_n, .irq);
  hmc_adc_model adc_u (.ch(adc_ch), .offs(offs), .data(adc_data));
  // free-running 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    rv = rdata;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // bounded wait for eoc_n, counting busy cycles and top channel seen
  task automatic wait_lvl(input logic lvl);
    cnt = 0;
    cyc = 0;
    mx  = 0;
    for (int i = 0; i < 20000; i++) begin
      @(posedge ref_clk);
      cyc++;
      if (eoc_n === lvl) return;
      if (adc_conv === 1'b1) begin
        cnt++;
        if (adc_ch > mx) mx = adc_ch;
      end
    end
    n_errors++;
    report_and_stop();
  endtask
  initial begin
    {rstn, wr, rd, ext_trig, addr, wdata, offs} = '0;
    {n_errors, checked} = '0;
    exp_res = '{default: 12'h000};
    rows = '{'{32'h08, 4, CONV_FR_CYC}, '{32'h0A, 3, CONV_FR_CYC},
             '{32'h1C, 2, CONV_SR_CYC}, '{32'h18, 4, CONV_SR_CYC}};
    rst_tab = '{{8'h00, 32'h08}, {8'h04, 32'h01}, {8'h08, 32'h00},
                {8'h0C, 32'h00}, {8'h14, 32'h1000}, {8'h40, 32'h00}};
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    wr_reg(REG_IRQ_MASK, 32'h01);
    // one triggered cycle per configuration; host reads at typical spacing
    foreach (rows[i]) begin
      wr_reg(REG_CTRL, rows[i].ctrl);
      offs <= offs + 10'h0B7;
      @(posedge ref_clk);
      ext_trig <= 1'b1;
      @(posedge ref_clk);
      ext_trig <= 1'b0;
      wait_lvl(1'b0);
      cmp((cnt + 4) / rows[i].len, rows[i].nch);
      cmp(mx, rows[i].nch - 1);
      wait_lvl(1'b1);
      cmp(cyc, EOC_PULSE_CYC);
      for (int c = 0; c < rows[i].nch; c++) exp_res[c] = {offs, 2'(c)};
      repeat (rows[i].len * 40 / 43) @(posedge ref_clk);
      for (int c = 0; c < 4; c++) begin
        rd_reg(REG_RES_X + 8'(4 * c));
        cmp(rv, 32'(exp_res[c]));
        repeat (rows[i].len - 3) @(posedge ref_clk);
      end
      cmp(irq, 1'b1);
      wr_reg(REG_IRQ_STAT, 32'h01);
      repeat (2) @(negedge ref_clk);
      cmp(irq, 1'b0);
      $display("config row %0d done", i);
    end
    // without a trigger the sequencer must stay idle
    cnt = 0;
    repeat (3000) begin
      @(posedge ref_clk);
      if (adc_conv !== 1'b0) cnt++;
    end
    cmp(cnt, 0);
    $display("idle test done");
    // masked software trigger, then two requests while busy: one is lost
    wr_reg(REG_IRQ_MASK, 32'h00);
    wr_reg(REG_CTRL, 32'h0C);
    wr_reg(REG_TRIG, 32'h01);
    repeat (10) @(posedge ref_clk);
    ext_trig <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ext_trig <= 1'b0;
    wait_lvl(1'b0);
    cmp(irq, 1'b0);
    rd_reg(REG_IRQ_STAT);
    cmp(rv, 32'h03);
    wait_lvl(1'b1);
    // reset while the pending cycle runs
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(negedge ref_clk);
    cmp({adc_ch, irq, adc_conv, eoc_n}, 32'h01);
    cmp(rdata, 32'h00);
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rst_tab[i]) begin
      rd_reg(rst_tab[i][39:32]);
      cmp(rv, rst_tab[i][31:0]);
    end
    $display("trigger drop and reset test done");
    // internal trigger source, then continuous mode with no trigger at all
    wr_reg(REG_PERIOD, 32'h40);
    wr_reg(REG_CTRL, 32'h2C);
    wait_lvl(1'b0);
    cmp(mx, 1);
    wait_lvl(1'b1);
    offs <= offs + 10'h0B7;
    wr_reg(REG_CTRL, 32'h0D);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    cmp((cnt + 200) / CONV_FR_CYC, 2);
    // host paced by eoc: read y inside the first window after eoc rises
    wait_lvl(1'b1);
    repeat (CONV_FR_CYC * 40 / 43) @(posedge ref_clk);
    rd_reg(REG_RES_Y);
    cmp(rv, 32'({offs, CH_Y}));
    $display("trigger source test done");
    report_and_stop();
  end
endmodule // test_hmc_top

bind hmc_top hmc_top_asserts chk_u (.ref_clk, .rstn, .addr, .wdata, .wr, .rd,
  .rdata, .ext_trig, .adc_data, .adc_ch, .adc_conv, .eoc_n, .irq);
